// File: rtl/adcal_ctrl.sv
`timescale 1ns/100ps
// What this block does
// [RULE_01] dimming level follows the host-written 8-bit value outside fallback mode
// [RULE_02] fallback mode is active only while the fallback request pin is high
// [RULE_03] switching needs both dim pwm input and enable/uvlo input high, fallback too
// [RULE_04] in fallback the dimming level comes from the external level pin
// [RULE_05] outside fallback the external level pin is ignored entirely
// [RULE_06] in fallback a level pin below 100mV stops switching
// [RULE_07] host drops pwm and disconnects the load before calibrating
// [RULE_08] host sets calibration enable, then calibration start
// [RULE_09] calibration routine completes about 200us after start
// [RULE_10] done flag rises when the routine finishes
// [RULE_11] enable high: routine result is applied and read back
// [RULE_12] enable low: host-written value is applied and read back
// [RULE_13] enable low: start requests are ignored
// [RULE_14] programmed value 24 means ten percent dimming
// [RULE_15] host repeats calibration whenever pwm stays low long enough
// [RULE_16] gate drivers off while internal or external gate supply undervoltage
// [RULE_17] in fallback internal gate supply undervoltage does not affect switching
// [RULE_18] gate drivers off while dim pwm input is low
// [RULE_19] done flag clears when a new start is accepted
module adcal_ctrl
  import adcal_pkg::*;
(
  // clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   reset_i,
  // avalon-mm slave
  input  wire logic [3:0]             avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  output logic      [31:0]            avs_readdata_o,
  output logic                        avs_waitrequest_o,
  // device pins
  input  wire logic                   fallback_request_pin_i,
  input  wire logic                   dim_pwm_input_i,
  input  wire logic                   enable_uvlo_input_i,
  input  wire logic                   gate_supply_uv_i,
  input  wire logic                   ext_gate_supply_uv_i,
  input  wire logic                   level_pin_low_i,
  input  wire logic [DIM_W-1:0]       level_pin_code_i,
  // analog calibration engine
  input  wire logic [CAL_W-1:0]       cal_result_i,
  // outputs to the analog path
  output logic [DIM_W-1:0]            current_dim_setting_o,
  output logic [CAL_W-1:0]            cal_applied_o,
  output logic                        cal_run_o,
  output logic                        switch_enable_o,
  output logic                        irq_o
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int SYNC_W = 6 + DIM_W;

  logic [SYNC_W-1:0] pins_sync;
  logic              fallback;
  logic              pwm_in;
  logic              en_in;
  logic              uv_int;
  logic              uv_ext;
  logic              lvl_low;
  logic [DIM_W-1:0]  lvl_code;

  adcal_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .async_i   ({fallback_request_pin_i, dim_pwm_input_i, enable_uvlo_input_i,
                 gate_supply_uv_i, ext_gate_supply_uv_i, level_pin_low_i, level_pin_code_i}),
    .sync_o    (pins_sync)
  );

  assign {fallback, pwm_in, en_in, uv_int, uv_ext, lvl_low, lvl_code} = pins_sync;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [DIM_W-1:0]     analog_dim_level;
  logic                 cal_enable;
  logic [CAL_W-1:0]     cal_value;
  logic [CAL_W-1:0]     cal_routine_val;
  logic                 cal_done;
  logic [IRQ_W-1:0]     irq_status;
  logic [IRQ_W-1:0]     irq_mask;
  adcal_state_t         state;
  logic [CAL_CNT_W-1:0] cal_cnt;
  logic                 fallback_q;
  logic                 gate_off_q;
  logic                 ack;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] reg_addr);
    return addr == reg_addr;
  endfunction

  // one wait state: each request is answered on the edge after ack rises
  wire req       = (avs_read_i || avs_write_i) && !ack;
  // ack marks the answer cycle, so a write lands on the edge where the master sees waitrequest low
  wire wr        = avs_write_i && ack && avs_byteenable_i[0];
  wire wr_dim    = wr && hit(avs_address_i, ADDR_DIM_LEVEL);
  wire wr_ctrl   = wr && hit(avs_address_i, ADDR_DEV_CONTROL);
  wire wr_calc   = wr && hit(avs_address_i, ADDR_CAL_CONTROL);
  wire wr_calv   = wr && hit(avs_address_i, ADDR_CAL_VALUE);
  wire wr_irqs   = wr && hit(avs_address_i, ADDR_IRQ_STATUS);
  wire wr_irqm   = wr && hit(avs_address_i, ADDR_IRQ_MASK);

  // ---------------------------------------------------------------
  // switching and level selection
  // ---------------------------------------------------------------
  // internal undervoltage is masked in fallback, external one always counts
  wire uv_block     = (uv_int && !fallback) || uv_ext;          // [RULE_16] [RULE_17]
  wire level_stop   = fallback && lvl_low;                       // [RULE_06]
  wire next_switch  = pwm_in && en_in && !uv_block && !level_stop; // [RULE_03] [RULE_18]
  // level pin is only looked at in fallback; otherwise the programmed value
  wire [DIM_W-1:0] next_dim = fallback ? lvl_code : analog_dim_level; // [RULE_01] [RULE_04] [RULE_05]

  // ---------------------------------------------------------------
  // calibration sequencing
  // ---------------------------------------------------------------
  wire start_ok     = wr_calc && avs_writedata_i[CALC_START] && cal_enable; // [RULE_13]
  wire cal_finish   = (state == ADCAL_RUN) && (cal_cnt == CAL_CNT_W'(CAL_CYCLES - 1)); // [RULE_09]
  wire [CAL_W-1:0] applied = cal_enable ? cal_routine_val : cal_value; // [RULE_11] [RULE_12]

  wire [IRQ_W-1:0] irq_events;
  assign irq_events[IRQ_CAL_DONE] = cal_finish;
  assign irq_events[IRQ_FALLBACK] = fallback && !fallback_q;
  assign irq_events[IRQ_UV]       = uv_block && !gate_off_q;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  logic [31:0] rdata;

  always_comb begin
    rdata = UNMAPPED_READ;
    unique case (avs_address_i)
      ADDR_DIM_LEVEL:   rdata = {24'h000000, analog_dim_level};
      ADDR_DEV_CONTROL: rdata = {31'h00000000, cal_enable};
      ADDR_CAL_CONTROL: rdata = {29'h00000000, state == ADCAL_RUN, cal_done, 1'b0};
      ADDR_CAL_VALUE:   rdata = {24'h000000, applied};
      ADDR_STATUS:      rdata = {29'h00000000, gate_off_q, switch_enable_o, fallback_q};
      ADDR_IRQ_STATUS:  rdata = {29'h00000000, irq_status};
      ADDR_IRQ_MASK:    rdata = {29'h00000000, irq_mask};
      default:          rdata = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ack               <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
    end else begin
      ack               <= req;
      avs_waitrequest_o <= !req;
      avs_readdata_o    <= req ? rdata : 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      analog_dim_level <= DIM_LEVEL_RST;
      cal_enable       <= 1'b0;
      cal_value        <= CAL_VALUE_RST;
      irq_mask         <= '0;
    end else begin
      if (wr_dim) begin
        analog_dim_level <= avs_writedata_i[DIM_W-1:0]; // [RULE_01] [RULE_14]
      end
      if (wr_ctrl) begin
        cal_enable <= avs_writedata_i[CTRL_CAL_EN];
      end
      if (wr_calv) begin
        cal_value <= avs_writedata_i[CAL_W-1:0];
      end
      if (wr_irqm) begin
        irq_mask <= avs_writedata_i[IRQ_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // calibration state machine
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state           <= ADCAL_IDLE;
      cal_cnt         <= '0;
      cal_done        <= 1'b0;
      cal_routine_val <= CAL_VALUE_RST;
    end else begin
      unique case (state)
        ADCAL_IDLE, ADCAL_DONE: begin
          if (start_ok) begin
            state    <= ADCAL_RUN;
            cal_cnt  <= '0;
            cal_done <= 1'b0;                   // [RULE_19]
          end
        end
        ADCAL_RUN: begin
          cal_cnt <= cal_cnt + 1'b1;
          if (cal_finish) begin
            state           <= ADCAL_DONE;
            cal_done        <= 1'b1;            // [RULE_10]
            cal_routine_val <= cal_result_i;    // [RULE_11]
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // interrupts and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_status            <= '0;
      irq_o                 <= 1'b0;
      fallback_q            <= 1'b0;
      gate_off_q            <= 1'b0;
      switch_enable_o       <= 1'b0;
      current_dim_setting_o <= DIM_LEVEL_RST;
      cal_applied_o         <= CAL_VALUE_RST;
      cal_run_o             <= 1'b0;
    end else begin
      // a new event wins over a write-one clear in the same cycle
      irq_status            <= (irq_status & ~(wr_irqs ? avs_writedata_i[IRQ_W-1:0] : '0)) | irq_events;
      irq_o                 <= |(irq_status & irq_mask);
      fallback_q            <= fallback;                        // [RULE_02]
      gate_off_q            <= uv_block;
      switch_enable_o       <= next_switch;                     // [RULE_03] [RULE_18]
      current_dim_setting_o <= next_dim;                        // [RULE_04]
      cal_applied_o         <= applied;                         // [RULE_12]
      cal_run_o             <= (state == ADCAL_RUN) && !cal_finish;
    end
  end

endmodule

// File: common/adcal_pkg.sv
package adcal_pkg;

  // ---------------------------------------------------------------
  // register map (word addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_DIM_LEVEL    = 4'h0;
  localparam logic [3:0] ADDR_DEV_CONTROL  = 4'h1;
  localparam logic [3:0] ADDR_CAL_CONTROL  = 4'h2;
  localparam logic [3:0] ADDR_CAL_VALUE    = 4'h3;
  localparam logic [3:0] ADDR_STATUS       = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STATUS   = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK     = 4'h6;

  // ---------------------------------------------------------------
  // fields
  // ---------------------------------------------------------------
  localparam int DIM_W         = 8;
  localparam int CAL_W         = 8;
  localparam int CTRL_CAL_EN   = 0;
  localparam int CALC_START    = 0;
  localparam int CALC_DONE     = 1;
  localparam int CALC_BUSY     = 2;
  localparam int ST_FALLBACK   = 0;
  localparam int ST_SWITCH     = 1;
  localparam int ST_GATE_OFF   = 2;
  localparam int IRQ_W         = 3;
  localparam int IRQ_CAL_DONE  = 0;
  localparam int IRQ_FALLBACK  = 1;
  localparam int IRQ_UV        = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  DIM_LEVEL_RST  = 8'hFF;
  localparam logic [7:0]  CAL_VALUE_RST  = 8'h00;
  // programmed level that stands for ten percent dimming
  localparam logic [7:0]  DIM_LEVEL_10PCT = 8'h18;
  localparam logic [31:0] UNMAPPED_READ  = 32'h0000_0000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ       = 200;
  localparam int CAL_TIME_US   = 200;
  localparam int CAL_CYCLES    = CAL_TIME_US * CLK_MHZ;
  localparam int CAL_CNT_W     = 16;

  typedef enum logic [1:0] {
    ADCAL_IDLE,
    ADCAL_RUN,
    ADCAL_DONE
  } adcal_state_t;

endpackage

// File: rtl/adcal_sync.sv
`timescale 1ns/100ps
module adcal_sync
  import adcal_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  // asynchronous level in, synchronised level out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule

// File: verification/adcal_props.sv
`timescale 1ns/100ps
module adcal_props
  import adcal_pkg::*;
(
  // bus
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // pins and outputs
  input wire logic        fallback_request_pin_i,
  input wire logic        dim_pwm_input_i,
  input wire logic        enable_uvlo_input_i,
  input wire logic        gate_supply_uv_i,
  input wire logic        ext_gate_supply_uv_i,
  input wire logic        level_pin_low_i,
  input wire logic [7:0]  level_pin_code_i,
  input wire logic [7:0]  current_dim_setting_o,
  input wire logic        cal_run_o,
  input wire logic        switch_enable_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  int run_cnt;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !cal_run_o) run_cnt <= 0;
    else run_cnt <= run_cnt + 1;
  end
  sequence s_taken;
    (avs_read_i || avs_write_i) && avs_waitrequest_o && $past(avs_waitrequest_o);
  endsequence
  // four edges cover the two sync flops plus the output register
  sequence s_off;
    (!dim_pwm_input_i || !enable_uvlo_input_i || ext_gate_supply_uv_i) [*4];
  endsequence
  chk_one_wait: assert property (s_taken |=> !avs_waitrequest_o)
    else $error("request not answered");
  chk_answer_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer longer than one cycle");
  chk_idle_data: assert property (avs_waitrequest_o |-> avs_readdata_o == 32'h0)
    else $error("read data outside answer");
  chk_switch_on: assert property ((dim_pwm_input_i && enable_uvlo_input_i && !ext_gate_supply_uv_i &&
    (fallback_request_pin_i ? !level_pin_low_i : !gate_supply_uv_i)) [*4] |=> switch_enable_o)
    else $error("switching not enabled");
  chk_switch_off: assert property (s_off |=> !switch_enable_o)
    else $error("switching with pwm, enable or supply bad");
  chk_level_stop: assert property ((fallback_request_pin_i && level_pin_low_i) [*4] |=> !switch_enable_o)
    else $error("switching with level pin low");
  chk_int_uv: assert property ((!fallback_request_pin_i && gate_supply_uv_i) [*4] |=> !switch_enable_o)
    else $error("switching with gate supply low");
  chk_pin_level: assert property ((fallback_request_pin_i && $stable(level_pin_code_i)) [*4]
    |=> current_dim_setting_o == $past(level_pin_code_i))
    else $error("fallback level not from pin");
  chk_pin_ignored: assert property ((!fallback_request_pin_i && !avs_write_i) [*5]
    |-> $stable(current_dim_setting_o))
    else $error("level moved without write");
  chk_cal_time: assert property ($fell(cal_run_o) |-> run_cnt >= CAL_CYCLES - 1 && run_cnt <= CAL_CYCLES + 1)
    else $error("routine length wrong");
endmodule
bind adcal_ctrl adcal_props u_props (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .fallback_request_pin_i(fallback_request_pin_i), .dim_pwm_input_i(dim_pwm_input_i),
  .enable_uvlo_input_i(enable_uvlo_input_i), .gate_supply_uv_i(gate_supply_uv_i),
  .ext_gate_supply_uv_i(ext_gate_supply_uv_i), .level_pin_low_i(level_pin_low_i),
  .level_pin_code_i(level_pin_code_i), .current_dim_setting_o(current_dim_setting_o),
  .cal_run_o(cal_run_o), .switch_enable_o(switch_enable_o)
);

// File: verification/adcal_engine_model.sv
`timescale 1ns/100ps
module adcal_engine_model #(
  parameter logic [7:0] RESULT = 8'hA7
) (
  // clock and run request
  input  wire logic       ref_clk_i,
  input  wire logic       cal_run_i,
  // routine result
  output logic      [7:0] cal_result_o
);
  logic run_d = 1'b0;
  initial cal_result_o = 8'h3C;
  // outside a routine the value wanders, so a stale sample shows up
  always @(posedge ref_clk_i) begin
    run_d <= cal_run_i;
    if (cal_run_i || run_d) cal_result_o <= RESULT;
    else cal_result_o <= ~cal_result_o;
  end
endmodule

// File: verification/tb.sv
`timescale 1ns/100ps
module tb
  import adcal_pkg::*;
;
  logic        ref_clk, reset, avs_read, avs_write, waitreq, fb, pwm, en, uv, xuv, low, cal_run, sw, irq;
  logic [3:0]  avs_address, be;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0]  code, dim, cal_res, cal_app, pv, pc;
  logic [5:0]  pp;
  int          err_count = 0, n_checks = 0, cyc = 0, t0;
  adcal_ctrl uut (.ref_clk_i(ref_clk), .reset_i(reset), .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata), .avs_byteenable_i(be),
    .avs_readdata_o(avs_readdata), .avs_waitrequest_o(waitreq), .fallback_request_pin_i(fb),
    .dim_pwm_input_i(pwm), .enable_uvlo_input_i(en), .gate_supply_uv_i(uv), .ext_gate_supply_uv_i(xuv),
    .level_pin_low_i(low), .level_pin_code_i(code), .cal_result_i(cal_res), .current_dim_setting_o(dim),
    .cal_applied_o(cal_app), .cal_run_o(cal_run), .switch_enable_o(sw), .irq_o(irq));
  adcal_engine_model u_eng (.ref_clk_i(ref_clk), .cal_run_i(cal_run), .cal_result_o(cal_res));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // one calibration of 40000 cycles dominates the run
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      err_count++;
      stop_test;
    end
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge ref_clk); while (waitreq !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic pins(input logic [5:0] p, input logic [7:0] c);
    @(posedge ref_clk);
    {fb, pwm, en, uv, xuv, low} <= p;
    code <= c;
    repeat (4) @(posedge ref_clk);
  endtask
  function automatic logic exp_sw(input logic [5:0] p);
    return p[4] & p[3] & !p[1] & (p[5] ? !p[0] : !p[2]);
  endfunction
  initial begin
    {reset, avs_read, avs_write, avs_address, avs_writedata, be} = {3'b100, 36'h0, 4'hF};
    {fb, pwm, en, uv, xuv, low, code} = 14'h0;
    void'($urandom(12));
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    bus(0, ADDR_DIM_LEVEL, 0);
    chk(rd, DIM_LEVEL_RST);
    for (int i = 0; i < 24; i++) begin
      pv = (i == 0) ? DIM_LEVEL_10PCT : 8'($urandom);
      pp = 6'($urandom);
      pc = 8'($urandom);
      bus(1, ADDR_DIM_LEVEL, {24'h0, pv});
      pins(pp, pc);
      chk(sw, exp_sw(pp));
      chk(dim, pp[5] ? pc : pv);
      bus(0, ADDR_STATUS, 0);
      chk(rd, {29'h0, (pp[2] & !pp[5]) | pp[1], exp_sw(pp), pp[5]});
    end
    be <= 4'hE;
    bus(1, ADDR_DIM_LEVEL, 32'h33);
    be <= 4'hF;
    bus(0, ADDR_DIM_LEVEL, 0);
    chk(rd, pv);
    $display("test levels done");
    pins(6'h08, 8'h0);
    bus(1, ADDR_IRQ_STATUS, 32'h7);
    bus(1, ADDR_DEV_CONTROL, 0);
    bus(1, ADDR_CAL_VALUE, 32'h5A);
    bus(1, ADDR_CAL_CONTROL, 32'h1);
    repeat (3) @(posedge ref_clk);
    chk(cal_run, 0);
    chk(cal_app, 8'h5A);
    bus(0, ADDR_CAL_VALUE, 0);
    chk(rd, 32'h5A);
    bus(1, ADDR_DEV_CONTROL, 32'h1);
    t0 = cyc;
    bus(1, ADDR_CAL_CONTROL, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk(cal_run, 1);
    do bus(0, ADDR_CAL_CONTROL, 0); while (rd[CALC_DONE] !== 1'b1);
    chk(cyc - t0 >= CAL_CYCLES && cyc - t0 <= CAL_CYCLES + 8, 1);
    chk(cal_app, 8'hA7);
    bus(0, ADDR_CAL_VALUE, 0);
    chk(rd, 32'hA7);
    $display("test calibration done");
    bus(0, ADDR_IRQ_STATUS, 0);
    chk(rd, 32'h1);
    bus(1, ADDR_IRQ_MASK, 0);
    repeat (2) @(posedge ref_clk);
    chk(irq, 0);
    bus(1, ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1);
    bus(1, ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk(irq, 0);
    bus(0, 4'hF, 0);
    chk(rd, UNMAPPED_READ);
    bus(1, ADDR_CAL_CONTROL, 32'h1);
    bus(0, ADDR_CAL_CONTROL, 0);
    chk(rd[CALC_DONE], 0);
    $display("test irq and restart done");
    stop_test;
  end
endmodule
